// ==== rtl/pscfg_top.sv ====
// passive serial configuration loader, target side
// assumes open-drain lines are resolved outside from the _OE outputs
//
// Contract
// - sample data on each rising serial clock
// - request rising edge starts configuration
// - pull done line low once started
// - hold status low until power-on reset ends
// - delay select: low 100 ms, high 2 ms
// - our delay no longer than loader's
// - start only after status line released by all
// - initialize on 10 MHz oscillator, then off
// - release done, user mode after init
// - on error pull status line low
// - auto restart option restarts after error
// - auto restart: reset, pulse status low
// - shared done line starts init together
// - weak pull-ups on unless disabled, until user
`timescale 1ns/1ps
`default_nettype none
module pscfg_top #(
  parameter int unsigned POR_LONG_CYC = pscfg_pkg::POR_LONG_CYC,
  parameter int unsigned POR_SHORT_CYC = pscfg_pkg::POR_SHORT_CYC,
  parameter int unsigned INIT_TICKS = pscfg_pkg::INIT_TICKS,
  parameter int unsigned BITSTREAM_WORDS = pscfg_pkg::BITSTREAM_WORDS,
  parameter logic [31:0] SYNC_WORD = pscfg_pkg::SYNC_WORD
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic SERIAL_LOAD_CLOCK,
  input wire logic SERIAL_BIT_IN,
  input wire logic CONFIG_REQUEST_N,
  input wire logic POWER_ON_DELAY_SELECT,
  input wire logic WEAK_PULLUP_DISABLE,
  input wire logic AUTO_RESTART,
  input wire logic STATUS_FAULT_OD_N_I,
  output logic STATUS_FAULT_OD_N_O,
  output logic STATUS_FAULT_OD_N_OE,
  input wire logic LOAD_COMPLETE_OD_I,
  output logic LOAD_COMPLETE_OD_O,
  output logic LOAD_COMPLETE_OD_OE,
  output logic WEAK_PULLUP_EN,
  output logic INIT_OSC_ON,
  output logic USER_MODE,
  output logic LOAD_ERROR,
  output logic [pscfg_pkg::WORD_W-1:0] CFG_WORD,
  output logic CFG_WORD_VALID
);

  localparam int TW = pscfg_pkg::TIMER_W;
  localparam int WCW = 16;
  localparam int DW = $clog2(pscfg_pkg::OSC_DIV);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (POR_LONG_CYC >= (1 << TW) || POR_SHORT_CYC >= (1 << TW) || POR_SHORT_CYC < 1)
  begin : g_chk_por
    $error("pscfg_top: power-on delay does not fit the timer");
  end
  if (INIT_TICKS < 1 || INIT_TICKS >= (1 << TW)) begin : g_chk_init
    $error("pscfg_top: init tick count out of range");
  end
  if (BITSTREAM_WORDS < 1 || BITSTREAM_WORDS >= (1 << WCW)) begin : g_chk_words
    $error("pscfg_top: bitstream word count out of range");
  end
  if (pscfg_pkg::OSC_DIV < 2) begin : g_chk_div
    $error("pscfg_top: init oscillator divider below 2");
  end

  // ---------------------------------------------------------------
  // serial clock domain
  // ---------------------------------------------------------------
  pscfg_xfer_if #(.W(pscfg_pkg::WORD_W)) xfer ();

  pscfg_shift #(.W(pscfg_pkg::WORD_W)) u_shift (
    .serial_load_clock(SERIAL_LOAD_CLOCK),
    .sys_rst(SYS_RST),
    .serial_bit_in(SERIAL_BIT_IN),
    .xfer(xfer)
  );

  // ---------------------------------------------------------------
  // pin and toggle synchronisers
  // ---------------------------------------------------------------
  logic [pscfg_pkg::NPINS-1:0] pins;
  logic [pscfg_pkg::NPINS-1:0] p1_q;
  logic [pscfg_pkg::NPINS-1:0] p2_q;
  logic [pscfg_pkg::NPINS-1:0] p3_q;
  logic [pscfg_pkg::NPINS-1:0] pin_q;
  logic t1_q;
  logic t2_q;
  logic t3_q;
  logic tgl_q;
  logic tgl_seen_q;
  logic req_n_prev_q;
  logic word_new;
  logic req_rise;

  assign pins[pscfg_pkg::PIN_REQ_N] = CONFIG_REQUEST_N;
  assign pins[pscfg_pkg::PIN_STATUS] = STATUS_FAULT_OD_N_I;
  assign pins[pscfg_pkg::PIN_DONE] = LOAD_COMPLETE_OD_I;
  assign pins[pscfg_pkg::PIN_PDS] = POWER_ON_DELAY_SELECT;
  assign pins[pscfg_pkg::PIN_WPD] = WEAK_PULLUP_DISABLE;
  assign pins[pscfg_pkg::PIN_AUTO] = AUTO_RESTART;

  always_ff @(posedge CLK) begin
    p1_q <= pins;
    p2_q <= p1_q;
    p3_q <= p2_q;
    t1_q <= xfer.tgl;
    t2_q <= t1_q;
    t3_q <= t2_q;
  end

  // filtered levels start low, so a request input tied high
  // shows a rising edge right after power-up
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pin_q <= '0;
      tgl_q <= 1'b0;
      tgl_seen_q <= 1'b0;
    end else begin
      for (int i = 0; i < pscfg_pkg::NPINS; i++) begin
        pin_q[i] <= pscfg_pkg::agree(p2_q[i], p3_q[i], pin_q[i]);
      end
      tgl_q <= pscfg_pkg::agree(t2_q, t3_q, tgl_q);
      tgl_seen_q <= tgl_q;
    end
  end

  assign word_new = tgl_q ^ tgl_seen_q;
  assign req_rise = pin_q[pscfg_pkg::PIN_REQ_N] & ~req_n_prev_q;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  pscfg_pkg::pscfg_state_t st_q, st_d;
  logic [TW-1:0] tmr_q;
  logic [DW-1:0] div_q;
  logic [WCW-1:0] wcnt_q;
  logic por_done;
  logic err_done;
  logic init_done;
  logic osc_tick;
  logic status_low;
  logic bad_word;
  logic last_word;
  logic req_low;
  logic [TW-1:0] por_target;

  // keep ours within the loader's delay
  assign por_target = pin_q[pscfg_pkg::PIN_PDS] ? TW'(POR_SHORT_CYC - 1) : TW'(POR_LONG_CYC - 1);
  assign por_done = (tmr_q == por_target);
  assign err_done = (tmr_q == TW'(pscfg_pkg::ERR_PULSE_CYC - 1));
  assign osc_tick = (div_q == DW'(pscfg_pkg::OSC_DIV - 1));
  assign init_done = osc_tick && (tmr_q == TW'(INIT_TICKS - 1));
  assign status_low = ~pin_q[pscfg_pkg::PIN_STATUS];
  assign req_low = ~pin_q[pscfg_pkg::PIN_REQ_N];
  assign bad_word = word_new && (wcnt_q == '0) && (xfer.word != SYNC_WORD);
  // sync word is word 0 of the count and is never delivered
  assign last_word = word_new && (wcnt_q == WCW'(BITSTREAM_WORDS));

  always_comb begin
    st_d = st_q;
    case (st_q)
      pscfg_pkg::ST_POR: begin
        if (por_done) begin
          st_d = pscfg_pkg::ST_REQ;
        end
      end
      pscfg_pkg::ST_REQ: begin
        if (req_rise) begin
          st_d = pscfg_pkg::ST_WAIT;
        end
      end
      pscfg_pkg::ST_WAIT: begin
        // wait for all devices to release
        if (~status_low) begin
          st_d = pscfg_pkg::ST_LOAD;
        end
      end
      pscfg_pkg::ST_LOAD: begin
        if (status_low || bad_word) begin
          st_d = pscfg_pkg::ST_ERR;
        end else if (last_word) begin
          st_d = pscfg_pkg::ST_SYNC;
        end
      end
      pscfg_pkg::ST_SYNC: begin
        if (status_low) begin
          st_d = pscfg_pkg::ST_ERR;
        end else if (pin_q[pscfg_pkg::PIN_DONE]) begin
          st_d = pscfg_pkg::ST_INIT;
        end
      end
      pscfg_pkg::ST_INIT: begin
        if (init_done) begin
          st_d = pscfg_pkg::ST_USER;
        end
      end
      pscfg_pkg::ST_USER: begin
        st_d = pscfg_pkg::ST_USER;
      end
      pscfg_pkg::ST_ERR: begin
        if (err_done) begin
          st_d = pin_q[pscfg_pkg::PIN_AUTO] ? pscfg_pkg::ST_WAIT : pscfg_pkg::ST_HALT;
        end
      end
      pscfg_pkg::ST_HALT: begin
        st_d = pscfg_pkg::ST_HALT;
      end
      default: begin
        st_d = pscfg_pkg::ST_POR;
      end
    endcase
    // a low request forces the sequencer back to ST_REQ after power-on; the serial shifter is not reset
    if (req_low && st_q != pscfg_pkg::ST_POR) begin
      st_d = pscfg_pkg::ST_REQ;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_q <= pscfg_pkg::ST_POR;
    end else begin
      st_q <= st_d;
    end
  end

  // edge history parked low through power-on, so a
  // request tied high still shows its edge once the delay ends
  always_ff @(posedge CLK) begin
    if (SYS_RST || st_q == pscfg_pkg::ST_POR) begin
      req_n_prev_q <= 1'b0;
    end else begin
      req_n_prev_q <= pin_q[pscfg_pkg::PIN_REQ_N];
    end
  end

  // shared timer, restarted on every state change
  always_ff @(posedge CLK) begin
    if (SYS_RST || st_d != st_q) begin
      tmr_q <= '0;
    end else if (st_q == pscfg_pkg::ST_INIT) begin
      if (osc_tick) begin
        tmr_q <= tmr_q + TW'(1);
      end
    end else if (!(st_q == pscfg_pkg::ST_POR && por_done)) begin
      tmr_q <= tmr_q + TW'(1);
    end
  end

  // divide core clock to the init rate
  always_ff @(posedge CLK) begin
    if (SYS_RST || st_q != pscfg_pkg::ST_INIT) begin
      div_q <= '0;
    end else begin
      div_q <= osc_tick ? '0 : div_q + DW'(1);
    end
  end

  // ---------------------------------------------------------------
  // word intake
  // ---------------------------------------------------------------
  // words that arrive outside a load are dropped
  always_ff @(posedge CLK) begin
    if (SYS_RST || st_q != pscfg_pkg::ST_LOAD) begin
      wcnt_q <= '0;
    end else if (word_new) begin
      wcnt_q <= wcnt_q + WCW'(1);
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      CFG_WORD <= '0;
      CFG_WORD_VALID <= 1'b0;
    end else begin
      CFG_WORD_VALID <= (st_q == pscfg_pkg::ST_LOAD) && word_new && (wcnt_q != '0) && !bad_word && !status_low;
      if (st_q == pscfg_pkg::ST_LOAD && word_new) begin
        CFG_WORD <= xfer.word;
      end
    end
  end

  // ---------------------------------------------------------------
  // open-drain lines
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      STATUS_FAULT_OD_N_O <= 1'b0;
      STATUS_FAULT_OD_N_OE <= 1'b1;
    end else begin
      STATUS_FAULT_OD_N_O <= 1'b0;
      // drive low on error, also when restarting
      STATUS_FAULT_OD_N_OE <= (st_d == pscfg_pkg::ST_POR) || (st_d == pscfg_pkg::ST_ERR)
                              || (st_d == pscfg_pkg::ST_HALT) || (st_d == pscfg_pkg::ST_REQ && req_low);
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      LOAD_COMPLETE_OD_O <= 1'b0;
      LOAD_COMPLETE_OD_OE <= 1'b1;
    end else begin
      LOAD_COMPLETE_OD_O <= 1'b0;
      // done low from start, released at load end
      LOAD_COMPLETE_OD_OE <= !(st_d == pscfg_pkg::ST_SYNC || st_d == pscfg_pkg::ST_INIT
                               || st_d == pscfg_pkg::ST_USER);
    end
  end

  // ---------------------------------------------------------------
  // mode outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      INIT_OSC_ON <= pscfg_pkg::CTL_RST;
      USER_MODE <= pscfg_pkg::CTL_RST;
      LOAD_ERROR <= pscfg_pkg::CTL_RST;
      WEAK_PULLUP_EN <= 1'b1;
    end else begin
      INIT_OSC_ON <= (st_d == pscfg_pkg::ST_INIT);
      USER_MODE <= (st_d == pscfg_pkg::ST_USER);
      LOAD_ERROR <= (st_d == pscfg_pkg::ST_ERR) || (st_d == pscfg_pkg::ST_HALT);
      WEAK_PULLUP_EN <= (st_d != pscfg_pkg::ST_USER) && !pin_q[pscfg_pkg::PIN_WPD];
    end
  end

endmodule : pscfg_top
`default_nettype wire

// ==== rtl/pscfg_pkg.sv ====
// shared constants, states and helpers of the passive serial configuration loader
// assumes a 40 MHz core clock; all times below are converted with that period
package pscfg_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int NS_PER_MS = 1000000;
  localparam int POR_LONG_MS = 100;
  localparam int POR_SHORT_MS = 2;
  localparam int POR_LONG_CYC = POR_LONG_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int POR_SHORT_CYC = POR_SHORT_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int CLK_MHZ = 40;
  localparam int INIT_OSC_MHZ = 10;
  localparam int OSC_DIV = CLK_MHZ / INIT_OSC_MHZ;
  localparam int ERR_PULSE_NS = 2000;
  localparam int ERR_PULSE_CYC = (ERR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_TICKS = 64;
  localparam int TIMER_W = 23;

  // ---------------------------------------------------------------
  // stream layout and reset values
  // ---------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int BITSTREAM_WORDS = 16;
  localparam logic [31:0] SYNC_WORD = 32'h5a5a_c3c3;
  localparam logic CTL_RST = 1'b0;

  // ---------------------------------------------------------------
  // synchronised pin vector positions
  // ---------------------------------------------------------------
  localparam int PIN_REQ_N = 0;
  localparam int PIN_STATUS = 1;
  localparam int PIN_DONE = 2;
  localparam int PIN_PDS = 3;
  localparam int PIN_WPD = 4;
  localparam int PIN_AUTO = 5;
  localparam int NPINS = 6;

  typedef enum logic [3:0] {
    ST_POR, ST_REQ, ST_WAIT, ST_LOAD, ST_SYNC, ST_INIT, ST_USER, ST_ERR, ST_HALT
  } pscfg_state_t;

  // a change is accepted once the second and third stages agree
  function automatic logic agree(input logic s2, input logic s3, input logic held);
    agree = (s2 == s3) ? s3 : held;
  endfunction : agree

endpackage : pscfg_pkg

// ==== rtl/pscfg_xfer_if.sv ====
// carrier for completed words from the serial clock domain to the core
// assumes word stays stable for a full word time after each toggle
`timescale 1ns/1ps
`default_nettype none
interface pscfg_xfer_if #(parameter int W = pscfg_pkg::WORD_W);
  logic [W-1:0] word;
  logic tgl;
  modport link (output word, output tgl);
  modport core (input word, input tgl);
endinterface : pscfg_xfer_if
`default_nettype wire

// ==== rtl/pscfg_shift.sv ====
// serial clock domain: collects one bit per rising edge into words
// assumes sys_rst is the core reset, crossed here as a plain pin
`timescale 1ns/1ps
`default_nettype none
module pscfg_shift #(
  parameter int W = pscfg_pkg::WORD_W
) (
  input wire logic serial_load_clock,
  input wire logic sys_rst,
  input wire logic serial_bit_in,
  pscfg_xfer_if.link xfer
);

  localparam int CW = $clog2(W);

  // ---------------------------------------------------------------
  // checks and reset crossing
  // ---------------------------------------------------------------
  if (W < 2) begin : g_chk
    $error("pscfg_shift: word width below 2");
  end

  logic r1_q, r2_q, r3_q, lrst_q;
  logic [CW-1:0] cnt_q;
  logic [W-1:0] sh_q;
  logic [W-1:0] sh_d;
  logic [W-1:0] word_q;
  logic tgl_q;

  // only edges that the loader supplies move this reset; that is enough,
  // since the core ignores words outside a load anyway
  always_ff @(posedge serial_load_clock) begin
    r1_q <= sys_rst;
    r2_q <= r1_q;
    r3_q <= r2_q;
    lrst_q <= pscfg_pkg::agree(r2_q, r3_q, lrst_q);
  end

  // ---------------------------------------------------------------
  // shifter
  // ---------------------------------------------------------------
  // first bit lands in bit 0
  assign sh_d = {serial_bit_in, sh_q[W-1:1]};

  always_ff @(posedge serial_load_clock) begin
    if (lrst_q) begin
      sh_q <= '0;
      cnt_q <= '0;
    end else begin
      sh_q <= sh_d;
      cnt_q <= (cnt_q == CW'(W - 1)) ? '0 : cnt_q + CW'(1);
    end
  end

  // word register holds still for a whole word time after the toggle
  always_ff @(posedge serial_load_clock) begin
    if (lrst_q) begin
      word_q <= '0;
      tgl_q <= 1'b0;
    end else if (cnt_q == CW'(W - 1)) begin
      word_q <= sh_d;
      tgl_q <= ~tgl_q;
    end
  end

  assign xfer.word = word_q;
  assign xfer.tgl = tgl_q;

endmodule : pscfg_shift
`default_nettype wire

// ==== tb/pscfg_props.sv ====
// assertions on the loader top ports
// assumes binding onto pscfg_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module pscfg_props (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CONFIG_REQUEST_N,
  input wire logic WEAK_PULLUP_DISABLE,
  input wire logic AUTO_RESTART,
  input wire logic STATUS_FAULT_OD_N_OE,
  input wire logic LOAD_COMPLETE_OD_OE,
  input wire logic WEAK_PULLUP_EN,
  input wire logic INIT_OSC_ON,
  input wire logic USER_MODE,
  input wire logic LOAD_ERROR,
  input wire logic CFG_WORD_VALID
);
  localparam int ERR_CYC = pscfg_pkg::ERR_PULSE_CYC;
  logic [7:0] err_q;
  logic [3:0] quiet_q;
  logic wpd_q;
  always_ff @(posedge CLK) begin
    err_q <= LOAD_ERROR ? err_q + 8'h01 : 8'h00;
  end
  // strap filter needs a few cycles before the output follows
  always_ff @(posedge CLK) begin
    wpd_q <= WEAK_PULLUP_DISABLE;
    if (SYS_RST || wpd_q != WEAK_PULLUP_DISABLE) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'h8) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_reset_values: assert property (disable iff (1'b0) SYS_RST |=> STATUS_FAULT_OD_N_OE && LOAD_COMPLETE_OD_OE
    && !USER_MODE && !CFG_WORD_VALID) else $error("outputs not at reset values");
  a_word_in_load: assert property (CFG_WORD_VALID |-> $past(LOAD_COMPLETE_OD_OE) && !STATUS_FAULT_OD_N_OE
    && !USER_MODE) else $error("word outside load");
  a_user_done_free: assert property (USER_MODE |-> !LOAD_COMPLETE_OD_OE && !INIT_OSC_ON)
    else $error("user mode with done held");
  a_user_after_init: assert property ($rose(USER_MODE) |-> $past(INIT_OSC_ON))
    else $error("user mode without init");
  a_error_status: assert property (LOAD_ERROR |-> STATUS_FAULT_OD_N_OE && LOAD_COMPLETE_OD_OE)
    else $error("error without status low");
  a_error_pulse: assert property ($fell(LOAD_ERROR) && AUTO_RESTART && CONFIG_REQUEST_N |->
    err_q >= ERR_CYC - 1 && err_q <= ERR_CYC + 1 && !STATUS_FAULT_OD_N_OE) else $error("bad error pulse");
  a_request_low: assert property (!CONFIG_REQUEST_N [*7] |-> LOAD_COMPLETE_OD_OE && !USER_MODE
    && !INIT_OSC_ON) else $error("request low ignored");
  a_pullup_cfg: assert property (quiet_q == 4'h8 && !STATUS_FAULT_OD_N_OE && LOAD_COMPLETE_OD_OE |->
    WEAK_PULLUP_EN == !WEAK_PULLUP_DISABLE) else $error("pull-up enable wrong");
endmodule : pscfg_props
`default_nettype wire

// ==== tb/pscfg_cfgmem.sv ====
// behavioural serial configuration memory
// assumes img is loaded by the bench before a frame starts
`timescale 1ns/1ps
`default_nettype none
module pscfg_cfgmem #(
  parameter int NWORDS = 5,
  parameter int POR_NS = 8000
) (
  input wire logic status_line,
  input wire logic select_n,
  input wire logic flush,
  output logic sclk,
  output logic sdata,
  output logic oe_pull
);
  logic [31:0] img [0:NWORDS-1];
  int w;
  int b;
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    oe_pull = 1'b1;
    #(POR_NS);
    oe_pull = 1'b0;
    forever begin
      wait (status_line === 1'b1 && select_n === 1'b0);
      for (w = 0; w < NWORDS; w++) begin
        for (b = 0; b < 32; b++) begin
          sdata = img[w][b];
          #12 sclk = 1'b1;
          #24 sclk = 1'b0;
          #12;
        end
        // abort only on word boundaries
        if (status_line !== 1'b1 || select_n !== 1'b0) break;
      end
      sdata = ~sdata;
      #400;
      if (w == NWORDS && select_n === 1'b0) begin
        oe_pull = 1'b1;
        #3000 oe_pull = 1'b0;
      end
      wait (status_line !== 1'b1 || select_n === 1'b1);
    end
  end
  // clears the target shifter while it is in reset
  always @(posedge flush) begin
    repeat (6) begin
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
  end
  // exactly the edges the link side needs to leave reset, no bit counted
  always @(negedge flush) begin
    repeat (4) begin
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
  end
endmodule : pscfg_cfgmem
`default_nettype wire

// ==== tb/pscfg_top_test.sv ====
// self-checking bench for the configuration loader
// assumes behavioural memory model on the far side
`timescale 1ns/1ps
`default_nettype none
module pscfg_top_test;
  localparam int PL = 200;
  localparam int PS = 50;
  localparam int NW = 4;
  localparam int IT = 4;
  logic clk, rst, sclk, sdata, req_n, pds, wpd, auto_r, hpull, flush, mpull;
  logic st_o, st_oe, dn_o, dn_oe, osc_on, user, err, vld;
  logic [31:0] word;
  wire logic status_w;
  wire logic done_w;
  int failures;
  int samples_checked;
  int osc_cnt;
  logic [31:0] exp_q[$];
  assign status_w = (st_oe ? st_o : 1'b1) & ~mpull & ~hpull;
  assign done_w = dn_oe ? dn_o : 1'b1;
  pscfg_top #(.POR_LONG_CYC(PL), .POR_SHORT_CYC(PS), .INIT_TICKS(IT), .BITSTREAM_WORDS(NW)) u_pscfg_top (
    .CLK(clk), .SYS_RST(rst), .SERIAL_LOAD_CLOCK(sclk), .SERIAL_BIT_IN(sdata),
    .CONFIG_REQUEST_N(req_n), .POWER_ON_DELAY_SELECT(pds), .WEAK_PULLUP_DISABLE(wpd),
    .AUTO_RESTART(auto_r), .STATUS_FAULT_OD_N_I(status_w), .STATUS_FAULT_OD_N_O(st_o),
    .STATUS_FAULT_OD_N_OE(st_oe), .LOAD_COMPLETE_OD_I(done_w), .LOAD_COMPLETE_OD_O(dn_o),
    .LOAD_COMPLETE_OD_OE(dn_oe), .WEAK_PULLUP_EN(), .INIT_OSC_ON(osc_on), .USER_MODE(user),
    .LOAD_ERROR(err), .CFG_WORD(word), .CFG_WORD_VALID(vld));
  pscfg_cfgmem #(.NWORDS(NW + 1)) u_mem (.status_line(status_w), .select_n(done_w), .flush(flush),
    .sclk(sclk), .sdata(sdata), .oe_pull(mpull));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic give_verdict();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // result watcher: oldest note against each delivered word
  always @(posedge clk) begin
    if (vld === 1'b1) chk_word(word, exp_q.size() > 0 ? exp_q.pop_front() : ~word);
    if (osc_on === 1'b1) osc_cnt++;
  end
  task automatic do_reset(input logic sel, input logic a);
    @(posedge clk);
    rst <= 1'b1;
    flush <= 1'b1;
    pds <= sel;
    auto_r <= a;
    wpd <= 1'($urandom);
    req_n <= 1'b1;
    hpull <= 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    flush <= 1'b0;
    exp_q.delete();
    osc_cnt = 0;
  endtask : do_reset
  task automatic load_case(input logic sel, input logic a, input logic bad, input logic pull);
    int n;
    int p;
    logic [31:0] sw;
    p = sel ? PS : PL;
    sw = pscfg_pkg::SYNC_WORD;
    for (n = 1; n <= NW; n++) u_mem.img[n] = $urandom;
    u_mem.img[0] = bad ? ~sw : sw;
    do_reset(sel, a);
    for (n = 0; n < 3 * PL && st_oe !== 1'b0; n++) @(posedge clk);
    chk_bit(n >= p && n <= p + 16, 1'b1);
    if (!bad && !pull) for (n = 1; n <= NW; n++) exp_q.push_back(u_mem.img[n]);
    if (pull) begin
      for (n = 0; n < 2000 && status_w !== 1'b1; n++) @(posedge clk);
      repeat (10) @(posedge clk);
      hpull <= 1'b1;
      repeat (8) @(posedge clk);
      hpull <= 1'b0;
    end
    if (bad || pull) begin
      for (n = 0; n < 2000 && err !== 1'b1; n++) @(posedge clk);
      chk_bit(err, 1'b1);
      u_mem.img[0] = sw;
      for (n = 1; n <= NW; n++) exp_q.push_back(u_mem.img[n]);
      if (!a) begin
        repeat (150) @(posedge clk);
        chk_bit(st_oe & err, 1'b1);
        req_n <= 1'b0;
        repeat (10) @(posedge clk);
        req_n <= 1'b1;
      end
    end
    for (n = 0; n < 3000 && user !== 1'b1; n++) @(posedge clk);
    chk_bit(user, 1'b1);
    chk_bit(dn_oe, 1'b0);
    chk_bit(osc_cnt >= 4 * (IT - 1) && osc_cnt <= 4 * (IT + 1), 1'b1);
  endtask : load_case
  initial begin
    rst = 1'b1;
    flush = 1'b0;
    req_n = 1'b1;
    pds = 1'b1;
    wpd = 1'b0;
    auto_r = 1'b0;
    hpull = 1'b0;
    failures = 0;
    samples_checked = 0;
    osc_cnt = 0;
    void'($urandom(32'h5f9d));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    load_case(1'b0, 1'b0, 1'b0, 1'b0);
    load_case(1'b1, 1'b0, 1'b1, 1'b0);
    load_case(1'b1, 1'b1, 1'b1, 1'b0);
    load_case(1'b1, 1'b1, 1'b0, 1'b1);
    give_verdict();
  end
  // watchdog well beyond the four loads
  initial begin
    #400000;
    failures++;
    give_verdict();
  end
endmodule : pscfg_top_test
bind pscfg_top pscfg_props u_props (.*);
`default_nettype wire
